// >>> tb/bsp_ctrl_model.sv
`timescale 1ns/1ns
module bsp_ctrl_model
(
   output logic      scan_clock,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   int gap;
   initial
   begin
      scan_clock = 1'b0;
      tms = 1'b0;
      tdi = 1'b0;
   end
   task automatic step(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      #8 scan_clock = 1'b1;
      q = tdo;
      #(7 + gap) scan_clock = 1'b0;
   endtask
   task automatic tap_reset;
      logic q;
      repeat (5) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
   task automatic scan(input logic ir, input int n, input logic [23:0] din,
                       output logic [23:0] dout);
      logic q;
      dout = '0;
      step(1'b0, 1'b0, q);
      step(1'b1, 1'b0, q);
      if (ir)
         step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++)
      begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule

// >>> tb/bsp_tap_monitor.sv
`timescale 1ns/1ns
module bsp_tap_monitor
(
   input wire logic       sys_clk,
   input wire logic       rst,
   input wire logic       scan_clock,
   input wire logic       scan_fuse,
   input wire logic       prog_ok,
   input wire logic       security_fuse,
   input wire logic [2:0] pin_in,
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe_n,
   input wire logic [2:0] user_out,
   input wire logic [2:0] user_oe_n,
   input wire logic [2:0] user_in,
   input wire logic [3:0] pad_in,
   input wire logic [3:0] pad_out,
   input wire logic [3:0] pad_oe_n,
   input wire logic [3:0] core_out,
   input wire logic [3:0] core_oe_n,
   input wire logic [3:0] core_in,
   input wire logic       probe_out_a,
   input wire logic       probe_out_b,
   input wire logic       probe_chain_select,
   input wire logic       user_dr_sel,
   input wire logic       user_dr_capture,
   input wire logic       user_dr_shift,
   input wire logic       user_dr_update,
   input wire logic       user_dr_tdi
);
   logic [2:0] strap_reg;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         strap_reg <= {scan_fuse, prog_ok, security_fuse};
   end
   AST_USER_IN:
   assert property (@(posedge sys_clk) disable iff (rst)
      !$past(rst) && !$past(rst, 2) |-> user_in == $past(pin_in, 2))
      else $error("user_in is not pin_in two cycles late");
   AST_USER_PINS:
   assert property (@(posedge sys_clk) disable iff (rst) !strap_reg[2] |->
      pin_out == user_out && pin_oe_n == user_oe_n && pad_out == core_out
      && pad_oe_n == core_oe_n && core_in == pad_in)
      else $error("pins not in user mode");
   AST_SCAN_PINS:
   assert property (@(posedge sys_clk) disable iff (rst) strap_reg[2]
      |-> pin_out[1:0] == 2'h0 && pin_oe_n[1:0] == 2'h3)
      else $error("scan input pins driven");
   AST_PROBE_SEC:
   assert property (@(posedge sys_clk) disable iff (rst)
      !strap_reg[1] || strap_reg[0] |-> !probe_out_a && !probe_out_b)
      else $error("probe output while secured");
   AST_FUSE_OFF:
   assert property (@(posedge sys_clk) disable iff (rst)
      !strap_reg[2] |-> !probe_chain_select && !user_dr_sel)
      else $error("scan path selected with scan disabled");
   AST_USER_SEL:
   assert property (@(posedge scan_clock) disable iff (rst)
      user_dr_capture || user_dr_shift || user_dr_update |-> user_dr_sel)
      else $error("user strobe without user select");
   AST_CAP_NEXT:
   assert property (@(posedge scan_clock) disable iff (rst)
      user_dr_capture |=> !user_dr_capture && !user_dr_update)
      else $error("bad state after capture");
   AST_UPD_NEXT:
   assert property (@(posedge scan_clock) disable iff (rst)
      user_dr_update |=> !user_dr_shift && !user_dr_update)
      else $error("bad state after update");
   AST_USER_TDI:
   assert property (@(posedge scan_clock) disable iff (rst)
      user_dr_tdi == pin_in[0])
      else $error("user data input not serial input");
   AST_TDO_OE:
   assert property (@(posedge scan_clock) disable iff (rst)
      strap_reg[2] && (user_dr_capture || user_dr_shift || user_dr_update)
      |-> pin_oe_n[2] == !user_dr_shift)
      else $error("serial output enable outside shift");
   cover property (@(posedge scan_clock) user_dr_update);
   cover property (@(posedge scan_clock) !pin_oe_n[2]);
   cover property (@(posedge sys_clk) $rose(probe_chain_select));
endmodule
bind bsp_tap_port bsp_tap_monitor mon (.*);

// >>> tb/tb_bsp_tap_port.sv
`timescale 1ns/1ns
module tb_bsp_tap_port;
   import bsp_pkg::*;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
   logic        sys_clk, rst, scan_clock, scan_fuse, prog_ok, security_fuse;
   logic        probe_out_a, probe_out_b, probe_chain_select, user_dr_sel;
   logic        user_dr_capture, user_dr_shift, user_dr_update, user_dr_tdi;
   logic        user_dr_tdo, tms, tdi, ureg;
   logic [2:0]  pin_in, pin_out, pin_oe_n, user_out, user_oe_n, user_in;
   logic [3:0]  pad_in, pad_out, pad_oe_n, core_out, core_oe_n, core_in;
   logic [15:0] probe_nodes, seed;
   logic [23:0] din, dout;
   logic [11:0] bsr;
   int          checked, err_count, n;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic int dr_len(input logic [2:0] c);
      return c <= IR_INTEST ? BSR_W : c == IR_PROBE ? PRB_W : 1;
   endfunction
   task automatic finish_test;
      $display("Checked %0d, errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic new_stim;
      seed = lfsr(seed);
      din[15:0] = seed;
      seed = lfsr(seed);
      din[23:16] = seed[7:0];
      @(posedge sys_clk);
      {pad_in, core_out, core_oe_n} <= seed[15:4];
      {user_out, user_oe_n} <= din[5:0];
      probe_nodes <= din[23:8];
   endtask
   task automatic check_pads(input logic [2:0] c);
      case (c)
         IR_EXTEST, IR_CLAMP:
            `CHK({pad_oe_n, pad_out}, bsr[11:4])
         IR_HIGHZ:
            `CHK(pad_oe_n, 4'hF)
         IR_INTEST:
            `CHK({pad_oe_n, core_in}, {4'hF, bsr[3:0]})
         default:
            `CHK({pad_oe_n,pad_out,core_in},{core_oe_n,core_out,pad_in})
      endcase
   endtask
   bsp_tap_port uut (.*);
   bsp_ctrl_model ctrl (.scan_clock(scan_clock), .tms(tms), .tdi(tdi),
                        .tdo(pin_in[2]));
   assign pin_in = (~pin_oe_n & pin_out)
                 | (pin_oe_n & {~pin_out[2], tms, tdi});
   assign user_dr_tdo = ureg;
   always @(posedge scan_clock)
      ureg <= user_dr_capture ? 1'b0 : user_dr_shift ? user_dr_tdi : ureg;
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial
   begin
      #400_000;
      err_count++;
      finish_test();
   end
   initial
   begin
      rst = 1'b1;
      scan_fuse = 1'b1;
      prog_ok = 1'b1;
      security_fuse = 1'b0;
      ureg = 1'b0;
      seed = 16'h10B2;
      {pad_in, core_out, core_oe_n, user_out, user_oe_n} = '0;
      probe_nodes = '0;
      @(posedge sys_clk);
      ctrl.tap_reset();
      repeat (19) @(posedge sys_clk);
      rst <= 1'b0;
      ctrl.tap_reset();
      din = 24'h00_00A5;
      ctrl.scan(1'b0, 8, din, dout);
      `CHK(dout[7:0], {din[6:0], 1'b0})
      for (int c = 0; c < 8; c++)
      begin
         new_stim();
         if (c == 7)
            din = '1;
         ctrl.gap = c[0] ? 40 : 0;
         n = dr_len(c[2:0]);
         ctrl.scan(1'b1, IR_W, {21'h0, c[2:0]}, dout);
         `CHK(dout[2:0], IR_CAPTURE)
         `CHK(probe_chain_select, c == 3)
         `CHK(user_dr_sel, c == 4)
         ctrl.scan(1'b0, n + 8, din, dout);
         `CHK(dout >> n, {16'h0, din[7:0]})
         if (c == 0)
            `CHK(dout[3:0], pad_in)
         if (c == 1)
            `CHK(dout[11:0], {core_oe_n, core_out, pad_in})
         if (c < 3)
            bsr = din[19:8];
         repeat (8) @(negedge sys_clk);
         check_pads(c[2:0]);
         if (c == 3)
         begin
            `CHK(probe_out_a, probe_nodes[din[11:8]])
            `CHK(probe_out_b, probe_nodes[din[15:12]])
         end
      end
      @(posedge sys_clk);
      rst <= 1'b1;
      scan_fuse <= 1'b0;
      security_fuse <= 1'b1;
      ctrl.tap_reset();
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4)
      begin
         new_stim();
         repeat (3) @(negedge sys_clk);
         `CHK({pin_oe_n, pin_out}, {user_oe_n, user_out})
         `CHK(user_in, pin_in)
         `CHK({probe_out_a, probe_out_b, probe_chain_select}, 3'h0)
         check_pads(IR_BYPASS);
      end
      finish_test();
   end
endmodule

// >>> verilog/bsp_pkg.sv
package bsp_pkg;

   localparam int          IR_W        = 3;
   localparam int          PAD_N       = 4;
   localparam int          BSR_W       = 3 * PAD_N;
   localparam int          BSR_IN_LO   = 0;
   localparam int          BSR_OUT_LO  = PAD_N;
   localparam int          BSR_OE_LO   = 2 * PAD_N;
   localparam int          PRB_W       = 8;
   localparam int          PRB_SEL_W   = 4;
   localparam int          PRB_NODES   = 16;
   localparam int          UIO_N       = 3;
   localparam int          PIN_TDI     = 0;
   localparam int          PIN_TMS     = 1;
   localparam int          PIN_TDO     = 2;

   localparam logic [2:0]  IR_EXTEST   = 3'h0;
   localparam logic [2:0]  IR_SAMPLE   = 3'h1;
   localparam logic [2:0]  IR_INTEST   = 3'h2;
   localparam logic [2:0]  IR_PROBE    = 3'h3;
   localparam logic [2:0]  IR_USER     = 3'h4;
   localparam logic [2:0]  IR_HIGHZ    = 3'h5;
   localparam logic [2:0]  IR_CLAMP    = 3'h6;
   localparam logic [2:0]  IR_BYPASS   = 3'h7;
   localparam logic [2:0]  IR_CAPTURE  = 3'h1;

   localparam logic [11:0] BSR_RST     = 12'h0000;
   localparam logic [7:0]  PRB_RST     = 8'h00;

   typedef enum logic [15:0] {
      TAP_RESET  = 16'h0001,
      TAP_IDLE   = 16'h0002,
      TAP_SEL_DR = 16'h0004,
      TAP_CAP_DR = 16'h0008,
      TAP_SH_DR  = 16'h0010,
      TAP_EX1_DR = 16'h0020,
      TAP_PA_DR  = 16'h0040,
      TAP_EX2_DR = 16'h0080,
      TAP_UPD_DR = 16'h0100,
      TAP_SEL_IR = 16'h0200,
      TAP_CAP_IR = 16'h0400,
      TAP_SH_IR  = 16'h0800,
      TAP_EX1_IR = 16'h1000,
      TAP_PA_IR  = 16'h2000,
      TAP_EX2_IR = 16'h4000,
      TAP_UPD_IR = 16'h8000
   } bsp_tap_t;

endpackage

// >>> verilog/bsp_tap_port.sv
`timescale 1ns/1ns
module bsp_tap_port
(
   input  wire logic                        sys_clk,
   input  wire logic                        rst,
   input  wire logic                        scan_clock,
   input  wire logic                        scan_fuse,
   input  wire logic                        prog_ok,
   input  wire logic                        security_fuse,
   input  wire logic [bsp_pkg::UIO_N-1:0]   pin_in,
   output logic      [bsp_pkg::UIO_N-1:0]   pin_out,
   output logic      [bsp_pkg::UIO_N-1:0]   pin_oe_n,
   input  wire logic [bsp_pkg::UIO_N-1:0]   user_out,
   input  wire logic [bsp_pkg::UIO_N-1:0]   user_oe_n,
   output logic      [bsp_pkg::UIO_N-1:0]   user_in,
   input  wire logic [bsp_pkg::PAD_N-1:0]   pad_in,
   output logic      [bsp_pkg::PAD_N-1:0]   pad_out,
   output logic      [bsp_pkg::PAD_N-1:0]   pad_oe_n,
   input  wire logic [bsp_pkg::PAD_N-1:0]   core_out,
   input  wire logic [bsp_pkg::PAD_N-1:0]   core_oe_n,
   output logic      [bsp_pkg::PAD_N-1:0]   core_in,
   input  wire logic [bsp_pkg::PRB_NODES-1:0] probe_nodes,
   output logic                             probe_out_a,
   output logic                             probe_out_b,
   output logic                             probe_chain_select,
   output logic                             user_dr_sel,
   output logic                             user_dr_capture,
   output logic                             user_dr_shift,
   output logic                             user_dr_update,
   output logic                             user_dr_tdi,
   input  wire logic                        user_dr_tdo
);
   import bsp_pkg::*;

   typedef struct packed {
      logic                  scan_en;
      logic                  prog_ok;
      logic                  secure;
      logic [UIO_N-1:0]      uin_s1;
      logic [UIO_N-1:0]      uin_s2;
      logic                  tgl_s1;
      logic                  tgl_s2;
      logic                  tgl_seen;
      logic [PRB_W-1:0]      probe_sel;
      logic                  probe_a;
      logic                  probe_b;
   } bsp_sys_t;

   typedef struct packed {
      logic                  rst_s1;
      logic                  rst_s2;
      logic                  en_s1;
      logic                  en_s2;
      logic [3*PAD_N-1:0]    cap_s1;
      logic [3*PAD_N-1:0]    cap_s2;
      bsp_tap_t              tap;
      logic [IR_W-1:0]       ir_sh;
      logic [IR_W-1:0]       ir;
      logic                  byp;
      logic [BSR_W-1:0]      bsr_sh;
      logic [BSR_W-1:0]      bsr_upd;
      logic [PRB_W-1:0]      prb_sh;
      logic [PRB_W-1:0]      prb_upd;
      logic                  prb_tgl;
   } bsp_scan_t;

   bsp_sys_t  sys_reg;
   bsp_sys_t  sys_next;
   bsp_scan_t scan_reg;
   bsp_scan_t scan_next;
   logic      tdo_reg;
   logic      tdo_oe_n_reg;
   logic      tdo_next;

   // TAP transitions from the sampled TMS level
   function automatic bsp_tap_t tap_step(input bsp_tap_t s, input logic tms);
      bsp_tap_t n;
      n = TAP_RESET;
      unique case (s)
         TAP_RESET:  n = tms ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   n = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: n = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: n = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  n = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: n = tms ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR:  n = tms ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: n = tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: n = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: n = tms ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: n = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  n = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: n = tms ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR:  n = tms ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: n = tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: n = tms ? TAP_SEL_DR : TAP_IDLE;
         default:    n = TAP_RESET;
      endcase
      return n;
   endfunction

   // Instructions that place the boundary register in the path
   function automatic logic is_bsr(input logic [IR_W-1:0] code);
      return (code == IR_EXTEST) || (code == IR_SAMPLE) || (code == IR_INTEST);
   endfunction

   // Instructions that put the boundary update cells on the pads
   function automatic logic drives_pads(input logic [IR_W-1:0] code);
      return (code == IR_EXTEST) || (code == IR_CLAMP);
   endfunction

   logic            tms_pin;
   logic            tdi_pin;
   logic            scan_live;
   logic [IR_W-1:0] ir_live;

   assign tdi_pin   = pin_in[PIN_TDI];
   assign tms_pin   = pin_in[PIN_TMS];
   assign scan_live = scan_reg.en_s2 & ~scan_reg.rst_s2;
   assign ir_live   = scan_live ? scan_reg.ir : IR_BYPASS;

   // System clock side: straps, pin sync, probe select and probe pins
   always_comb
   begin
      sys_next = sys_reg;
      sys_next.uin_s1 = pin_in;
      sys_next.uin_s2 = sys_reg.uin_s1;
      sys_next.tgl_s1 = scan_reg.prb_tgl;
      sys_next.tgl_s2 = sys_reg.tgl_s1;
      sys_next.tgl_seen = sys_reg.tgl_s2;
      if (sys_reg.tgl_s2 != sys_reg.tgl_seen)
      begin
         sys_next.probe_sel = scan_reg.prb_upd;
      end
      if (sys_reg.prog_ok && !sys_reg.secure)
      begin
         sys_next.probe_a = probe_nodes[sys_reg.probe_sel[PRB_SEL_W-1:0]];
         sys_next.probe_b = probe_nodes[sys_reg.probe_sel[PRB_W-1:PRB_SEL_W]];
      end
      else
      begin
         sys_next.probe_a = 1'b0;
         sys_next.probe_b = 1'b0;
      end
      if (rst)
      begin
         sys_next = '0;
         sys_next.scan_en = scan_fuse;
         sys_next.prog_ok = prog_ok;
         sys_next.secure  = security_fuse;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      sys_reg <= sys_next;
   end

   // Scan clock side: TAP, instruction, bypass, boundary, probe chain
   always_comb
   begin
      scan_next = scan_reg;
      scan_next.rst_s1 = rst;
      scan_next.rst_s2 = scan_reg.rst_s1;
      scan_next.en_s1  = sys_reg.scan_en;
      scan_next.en_s2  = scan_reg.en_s1;
      scan_next.cap_s1 = {core_oe_n, core_out, pad_in};
      scan_next.cap_s2 = scan_reg.cap_s1;
      scan_next.tap    = tap_step(scan_reg.tap, tms_pin);
      unique case (scan_reg.tap)
         TAP_RESET:
         begin
            scan_next.ir = IR_BYPASS;
         end
         TAP_CAP_IR:
         begin
            scan_next.ir_sh = IR_CAPTURE;
         end
         TAP_SH_IR:
         begin
            scan_next.ir_sh = {tdi_pin, scan_reg.ir_sh[IR_W-1:1]};
         end
         TAP_UPD_IR:
         begin
            scan_next.ir = scan_reg.ir_sh;
         end
         TAP_CAP_DR:
         begin
            if (is_bsr(scan_reg.ir))
            begin
               scan_next.bsr_sh = scan_reg.cap_s2;
            end
            if (scan_reg.ir == IR_PROBE)
            begin
               scan_next.prb_sh = scan_reg.prb_upd;
            end
            scan_next.byp = 1'b0;
         end
         TAP_SH_DR:
         begin
            if (is_bsr(scan_reg.ir))
            begin
               scan_next.bsr_sh = {tdi_pin, scan_reg.bsr_sh[BSR_W-1:1]};
            end
            else if (scan_reg.ir == IR_PROBE)
            begin
               scan_next.prb_sh = {tdi_pin, scan_reg.prb_sh[PRB_W-1:1]};
            end
            else if (scan_reg.ir != IR_USER)
            begin
               scan_next.byp = tdi_pin;
            end
         end
         TAP_UPD_DR:
         begin
            if (is_bsr(scan_reg.ir))
            begin
               scan_next.bsr_upd = scan_reg.bsr_sh;
            end
            if (scan_reg.ir == IR_PROBE)
            begin
               scan_next.prb_upd = scan_reg.prb_sh;
               scan_next.prb_tgl = ~scan_reg.prb_tgl;
            end
         end
         TAP_IDLE, TAP_SEL_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR,
         TAP_SEL_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR:
         begin
            scan_next.byp = scan_reg.byp;
         end
      endcase
      if (scan_reg.rst_s2 || !scan_reg.en_s2)
      begin
         scan_next.tap     = TAP_RESET;
         scan_next.ir      = IR_BYPASS;
         scan_next.ir_sh   = IR_CAPTURE;
         scan_next.byp     = 1'b0;
         scan_next.bsr_sh  = BSR_RST;
         scan_next.bsr_upd = BSR_RST;
         scan_next.prb_sh  = PRB_RST;
      end
      if (scan_reg.rst_s2)
      begin
         scan_next.prb_upd = PRB_RST;
         scan_next.prb_tgl = 1'b0;
      end
   end

   always_ff @(posedge scan_clock)
   begin
      scan_reg <= scan_next;
   end

   // Serial output selected by the current state and instruction
   always_comb
   begin
      tdo_next = 1'b0;
      if (scan_reg.tap == TAP_SH_IR)
      begin
         tdo_next = scan_reg.ir_sh[0];
      end
      else if (is_bsr(scan_reg.ir))
      begin
         tdo_next = scan_reg.bsr_sh[0];
      end
      else if (scan_reg.ir == IR_PROBE)
      begin
         tdo_next = scan_reg.prb_sh[0];
      end
      else if (scan_reg.ir == IR_USER)
      begin
         tdo_next = user_dr_tdo;
      end
      else
      begin
         tdo_next = scan_reg.byp;
      end
   end

   always_ff @(negedge scan_clock)
   begin
      if (scan_reg.rst_s2)
      begin
         tdo_reg      <= 1'b0;
         tdo_oe_n_reg <= 1'b1;
      end
      else
      begin
         tdo_reg      <= tdo_next;
         tdo_oe_n_reg <= ~((scan_reg.tap == TAP_SH_IR)
                           || (scan_reg.tap == TAP_SH_DR));
      end
   end

   // Shared pins: test port when the fuse is set, user I/O otherwise
   always_comb
   begin
      user_in = sys_reg.uin_s2;
      if (sys_reg.scan_en)
      begin
         pin_out  = '0;
         pin_oe_n = '1;
         pin_out[PIN_TDO]  = tdo_reg;
         pin_oe_n[PIN_TDO] = tdo_oe_n_reg;
      end
      else
      begin
         pin_out  = user_out;
         pin_oe_n = user_oe_n;
      end
   end

   // Pad and core multiplexing under the active instruction
   always_comb
   begin
      pad_out  = core_out;
      pad_oe_n = core_oe_n;
      core_in  = pad_in;
      if (drives_pads(ir_live))
      begin
         pad_out  = scan_reg.bsr_upd[BSR_OUT_LO +: PAD_N];
         pad_oe_n = scan_reg.bsr_upd[BSR_OE_LO +: PAD_N];
      end
      else if (ir_live == IR_HIGHZ)
      begin
         pad_out  = '0;
         pad_oe_n = '1;
      end
      else if (ir_live == IR_INTEST)
      begin
         pad_oe_n = '1;
         core_in  = scan_reg.bsr_upd[BSR_IN_LO +: PAD_N];
      end
   end

   // User data-register access and probe selection status
   assign probe_chain_select = scan_live && (scan_reg.ir == IR_PROBE);
   assign user_dr_sel     = scan_live && (scan_reg.ir == IR_USER);
   assign user_dr_capture = user_dr_sel && (scan_reg.tap == TAP_CAP_DR);
   assign user_dr_shift   = user_dr_sel && (scan_reg.tap == TAP_SH_DR);
   assign user_dr_update  = user_dr_sel && (scan_reg.tap == TAP_UPD_DR);
   assign user_dr_tdi     = tdi_pin;
   assign probe_out_a     = sys_reg.probe_a;
   assign probe_out_b     = sys_reg.probe_b;

endmodule
